// ---- inc/sfotp_map.svh ----
// Constants of the security-area command sequencer: opcodes, address fields, counts and times.
// Assumes it is included by bare name wherever one of the macros is used.
`ifndef SFOTP_MAP_SVH
`define SFOTP_MAP_SVH

// Opcodes
`define SFOTP_OP_PROG_AREA 8'h42
`define SFOTP_OP_READ_AREA 8'h48
`define SFOTP_OP_READ_PARAM 8'h5a
`define SFOTP_OP_RESET_ARM 8'h66
`define SFOTP_OP_RESET_GO 8'h99
`define SFOTP_OP_WRITE_EN 8'h06
`define SFOTP_OP_WRITE_DIS 8'h04

// Address field positions and required values
`define SFOTP_ADDR_HI_MSB 23
`define SFOTP_ADDR_HI_LSB 16
`define SFOTP_ADDR_AREA_MSB 15
`define SFOTP_ADDR_AREA_LSB 12
`define SFOTP_ADDR_GAP_MSB 11
`define SFOTP_ADDR_GAP_LSB 9
`define SFOTP_ADDR_OFS_MSB 8
`define SFOTP_AREA_1 4'h1
`define SFOTP_AREA_3 4'h3

// Frame bit counts
`define SFOTP_OPCODE_BITS 6'h08
`define SFOTP_ADDR_END_BITS 6'h20
`define SFOTP_DUMMY_END_BITS 6'h28

// Reset values, fill patterns and the last low offset
`define SFOTP_ERASED_BYTE 8'hff
`define SFOTP_OFS_LAST 8'hff

// Clock and times
`define SFOTP_CLK_PERIOD_NS 40
`define SFOTP_T_RST_US 30
`define SFOTP_T_PROG_US 2000
`define SFOTP_RST_CYCLES ((`SFOTP_T_RST_US * 1000 + `SFOTP_CLK_PERIOD_NS - 1) / `SFOTP_CLK_PERIOD_NS)
`define SFOTP_PROG_CYCLES ((`SFOTP_T_PROG_US * 1000) / `SFOTP_CLK_PERIOD_NS)

`endif

// ---- inc/sfotp_pkg.sv ----
// Types of the security-area command sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sfotp_pkg;

    // Serial frame phase
    typedef enum logic [2:0] {
        SFOTP_ST_OPCODE = 3'h0,
        SFOTP_ST_ADDR = 3'h1,
        SFOTP_ST_DUMMY = 3'h2,
        SFOTP_ST_RD_DATA = 3'h3,
        SFOTP_ST_PG_DATA = 3'h4,
        SFOTP_ST_SKIP = 3'h5
    } sfotp_state_type;

    // Self-timed engine phase
    typedef enum logic [1:0] {
        SFOTP_ENG_IDLE = 2'h0,
        SFOTP_ENG_WAIT = 2'h1,
        SFOTP_ENG_COMMIT = 2'h2,
        SFOTP_ENG_RECOVER = 2'h3
    } sfotp_eng_type;

endpackage

// ---- inc/sfotp_if.sv ----
// Interfaces between the sequencer core and its link receiver and storage array.
// Assumes all members are driven and read on clk_sys.
`timescale 1ns/1ns

// Synchronised link events
interface sfotp_link_if;
    logic cs_active; // Chip select low, synchronised
    logic cs_rise; // Frame end pulse
    logic sclk_rise; // Sampling edge pulse
    logic sclk_fall; // Shift-out edge pulse
    logic si_bit; // Input bit valid with sclk_rise
    modport rx (output cs_active, cs_rise, sclk_rise, sclk_fall, si_bit);
    modport core (input cs_active, cs_rise, sclk_rise, sclk_fall, si_bit);
endinterface

// Storage array access
interface sfotp_mem_if;
    logic [1:0] rd_area; // Area 1..3
    logic [8:0] rd_offset; // Byte offset
    logic [7:0] rd_data; // Combinational read data
    logic wr_en; // Program one byte
    logic [1:0] wr_area;
    logic [8:0] wr_offset;
    logic [7:0] wr_data;
    modport array (input rd_area, rd_offset, wr_en, wr_area, wr_offset, wr_data, output rd_data);
    modport core (output rd_area, rd_offset, wr_en, wr_area, wr_offset, wr_data, input rd_data);
endinterface

// ---- rtl/sfotp_link_rx.sv ----
// Link receiver: brings chip select, serial clock and input line into clk_sys and finds edges.
// Assumes the serial clock is much slower than clk_sys (at least four clk_sys periods per half).
`timescale 1ns/1ns

module sfotp_link_rx (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_si,
    sfotp_link_if.rx link
);

    logic [2:0] cs_sync; // Chip select chain, bit 0 first stage
    logic [2:0] sclk_sync; // Serial clock chain
    logic [1:0] si_sync; // Input line chain

    ////////////////////////////////////////////////////////////////////////////////
    // Two-stage synchronisers plus one history stage for edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cs_sync <= 3'h7;
            sclk_sync <= 3'h0;
            si_sync <= 2'h0;
        end else begin
            cs_sync <= {cs_sync[1:0], spi_cs_n};
            sclk_sync <= {sclk_sync[1:0], spi_sclk};
            si_sync <= {si_sync[0], spi_si};
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Edge pulses from the second and third stages only
    assign link.cs_active = ~cs_sync[1];
    assign link.cs_rise = cs_sync[1] & ~cs_sync[2];
    assign link.sclk_rise = sclk_sync[1] & ~sclk_sync[2] & ~cs_sync[1];
    assign link.sclk_fall = ~sclk_sync[1] & sclk_sync[2] & ~cs_sync[1];
    assign link.si_bit = si_sync[1];

endmodule

// ---- rtl/sfotp_otp_array.sv ----
// Storage for the three 512-byte security areas, with bit-clearing program semantics.
// Assumes area codes 1..3 only; the core writes only those areas and discards read data for area 0.
`timescale 1ns/1ns
`include "sfotp_map.svh"

module sfotp_otp_array #(
    parameter int AREA_BYTES = 512
) (
    input wire logic clk_sys,
    sfotp_mem_if.array mem
);

    localparam int DEPTH = 3 * AREA_BYTES;

    logic [7:0] cells [0:DEPTH-1]; // Non-volatile cells, erased at power-up
    logic [10:0] rd_index; // Flat read index
    logic [10:0] wr_index; // Flat write index

    generate
        if (AREA_BYTES != 512) begin : g_bad_size
            $error("sfotp_otp_array: AREA_BYTES must be 512");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up erased contents
    initial begin
        for (int i = 0; i < DEPTH; i++) begin
            cells[i] = `SFOTP_ERASED_BYTE;
        end
    end

    // Flat index from area and offset
    assign rd_index = {mem.rd_area - 2'h1, mem.rd_offset};
    assign wr_index = {mem.wr_area - 2'h1, mem.wr_offset};
    assign mem.rd_data = cells[rd_index];

    ////////////////////////////////////////////////////////////////////////////////
    // Programming only clears bits: each cell takes the AND of its old value and the new data
    always_ff @(posedge clk_sys) begin
        if (mem.wr_en) begin
            cells[wr_index] <= cells[wr_index] & mem.wr_data;
        end
    end

endmodule

// ---- rtl/sfotp_seq.sv ----
// Security-area command sequencer: program, read, parameter read and two-step soft reset.
// Assumes pins arrive asynchronously and the status register logic sits outside this block.
`timescale 1ns/1ns
`include "sfotp_map.svh"

module sfotp_seq #(
    parameter int PROG_CYCLES = `SFOTP_PROG_CYCLES,
    parameter int RST_CYCLES = `SFOTP_RST_CYCLES
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_si,
    input wire logic [2:0] otp_area_lock_bits,
    output logic spi_so,
    output logic spi_so_oe,
    output logic busy_in_progress,
    output logic write_enable_latch,
    output logic soft_reset_pulse,
    output logic reset_recovery,
    output logic param_read_active
);

    localparam int CNT_MAX = (PROG_CYCLES > RST_CYCLES) ? PROG_CYCLES : RST_CYCLES;
    localparam int CNT_W = $clog2(CNT_MAX + 1);

    generate
        if (PROG_CYCLES < 1 || RST_CYCLES < 1) begin : g_bad_counts
            $error("sfotp_seq: PROG_CYCLES and RST_CYCLES must be at least 1");
        end
    endgenerate

    sfotp_link_if link ();
    sfotp_mem_if mem ();

    sfotp_pkg::sfotp_state_type state; // Frame phase
    sfotp_pkg::sfotp_eng_type eng; // Engine phase
    logic [5:0] bit_cnt; // Rising edges in this frame
    logic [7:0] shift_in; // Input shift register
    logic [7:0] opcode; // Latched opcode
    logic [23:0] addr; // Latched address
    logic [7:0] out_shift; // Output shift register
    logic [2:0] out_cnt; // Output bit within byte
    logic [8:0] rd_offset; // Read pointer
    logic rd_valid; // Read address hits an area
    logic reset_armed; // Arm opcode seen last
    logic [7:0] pg_data [0:255]; // Program page buffer
    logic [255:0] pg_valid; // Buffer entries written
    logic [7:0] pg_ptr; // Buffer write pointer
    logic pg_base; // Offset bit 8 of the page
    logic [1:0] pg_area; // Target area
    logic [CNT_W-1:0] eng_cnt; // Engine timer
    logic [7:0] commit_idx; // Commit walk index
    logic [7:0] next_shift; // Shift register with new bit
    logic [23:0] next_addr; // Address with new bit
    logic [7:0] next_out; // Byte being driven
    logic addr_ok; // Address fields legal
    logic area_locked; // Lock bit of addressed area
    logic prog_ok; // Program may start collecting
    logic frame_end; // Select rose while not recovering
    logic short_cmd; // Frame held exactly one opcode
    logic cmd_wel_set; // Write enable accepted
    logic cmd_wel_clr; // Write disable accepted
    logic cmd_reset; // Reset pair completed
    logic pg_start; // Program cycle starts
    logic eng_done; // Program cycle completes

    ////////////////////////////////////////////////////////////////////////////////
    // Link receiver and storage
    sfotp_link_rx sfotp_link_rx_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk),
        .spi_si(spi_si),
        .link(link)
    );

    sfotp_otp_array sfotp_otp_array_inst (
        .clk_sys(clk_sys),
        .mem(mem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode and command qualification
    always_comb begin
        next_shift = {shift_in[6:0], link.si_bit};
        next_addr = {addr[22:0], link.si_bit};
        // Area code in 1..3 with zero high and gap fields
        addr_ok = (next_addr[`SFOTP_ADDR_HI_MSB:`SFOTP_ADDR_HI_LSB] == 8'h00)
            && (next_addr[`SFOTP_ADDR_GAP_MSB:`SFOTP_ADDR_GAP_LSB] == 3'h0)
            && (next_addr[`SFOTP_ADDR_AREA_MSB:`SFOTP_ADDR_AREA_LSB] >= `SFOTP_AREA_1)
            && (next_addr[`SFOTP_ADDR_AREA_MSB:`SFOTP_ADDR_AREA_LSB] <= `SFOTP_AREA_3);
        area_locked = otp_area_lock_bits[next_addr[13:12] - 2'h1];
        prog_ok = addr_ok && write_enable_latch && !area_locked && !busy_in_progress;
        frame_end = link.cs_rise && !reset_recovery;
        short_cmd = (state == sfotp_pkg::SFOTP_ST_SKIP) && (bit_cnt == `SFOTP_OPCODE_BITS);
        cmd_wel_set = frame_end && short_cmd && (opcode == `SFOTP_OP_WRITE_EN) && !busy_in_progress;
        cmd_wel_clr = frame_end && short_cmd && (opcode == `SFOTP_OP_WRITE_DIS) && !busy_in_progress;
        cmd_reset = frame_end && short_cmd && (opcode == `SFOTP_OP_RESET_GO) && reset_armed;
        // Program runs only when select rises on a byte boundary with data
        pg_start = frame_end && (state == sfotp_pkg::SFOTP_ST_PG_DATA)
            && (bit_cnt[2:0] == 3'h0) && (pg_valid != 256'h0);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame phase and bit counting on sampling edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_reset || !link.cs_active) begin
            state <= sfotp_pkg::SFOTP_ST_OPCODE;
            bit_cnt <= 6'h00;
        end else if (link.sclk_rise) begin
            // Saturate in skip so long frames never look like one opcode
            if (!(state == sfotp_pkg::SFOTP_ST_SKIP && bit_cnt == 6'h3f)) begin
                bit_cnt <= bit_cnt + 6'h01;
            end
            unique case (state)
                sfotp_pkg::SFOTP_ST_OPCODE: begin
                    if (bit_cnt == `SFOTP_OPCODE_BITS - 6'h01) begin
                        if (reset_recovery) begin
                            state <= sfotp_pkg::SFOTP_ST_SKIP;
                        end else if (next_shift == `SFOTP_OP_PROG_AREA || next_shift == `SFOTP_OP_READ_AREA
                            || next_shift == `SFOTP_OP_READ_PARAM) begin
                            state <= sfotp_pkg::SFOTP_ST_ADDR;
                        end else begin
                            state <= sfotp_pkg::SFOTP_ST_SKIP;
                        end
                    end
                end
                sfotp_pkg::SFOTP_ST_ADDR: begin
                    if (bit_cnt == `SFOTP_ADDR_END_BITS - 6'h01) begin
                        if (opcode != `SFOTP_OP_PROG_AREA) begin
                            state <= sfotp_pkg::SFOTP_ST_DUMMY;
                        end else if (prog_ok) begin
                            state <= sfotp_pkg::SFOTP_ST_PG_DATA;
                        end else begin
                            state <= sfotp_pkg::SFOTP_ST_SKIP;
                        end
                    end
                end
                sfotp_pkg::SFOTP_ST_DUMMY: begin
                    if (bit_cnt == `SFOTP_DUMMY_END_BITS - 6'h01) begin
                        state <= sfotp_pkg::SFOTP_ST_RD_DATA;
                    end
                end
                sfotp_pkg::SFOTP_ST_RD_DATA: begin
                    state <= sfotp_pkg::SFOTP_ST_RD_DATA;
                end
                sfotp_pkg::SFOTP_ST_PG_DATA: begin
                    state <= sfotp_pkg::SFOTP_ST_PG_DATA;
                end
                sfotp_pkg::SFOTP_ST_SKIP: begin
                    state <= sfotp_pkg::SFOTP_ST_SKIP;
                end
                default: begin
                    state <= sfotp_pkg::SFOTP_ST_SKIP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input shifting, opcode and address capture on rising edges
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shift_in <= 8'h00;
            opcode <= 8'h00;
            addr <= 24'h000000;
        end else if (link.sclk_rise) begin
            shift_in <= next_shift;
            if (state == sfotp_pkg::SFOTP_ST_OPCODE && bit_cnt == `SFOTP_OPCODE_BITS - 6'h01) begin
                opcode <= next_shift;
            end
            if (state == sfotp_pkg::SFOTP_ST_ADDR) begin
                addr <= next_addr;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read pointer and output shifting on falling edges
    assign next_out = (out_cnt == 3'h0) ? ((rd_valid && !param_read_active) ? mem.rd_data : `SFOTP_ERASED_BYTE)
        : out_shift;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || !link.cs_active) begin
            spi_so <= 1'b0;
            spi_so_oe <= 1'b0;
            out_cnt <= 3'h0;
            out_shift <= 8'h00;
            param_read_active <= 1'b0;
        end else if (link.sclk_rise && state == sfotp_pkg::SFOTP_ST_ADDR
            && bit_cnt == `SFOTP_ADDR_END_BITS - 6'h01) begin
            rd_offset <= next_addr[`SFOTP_ADDR_OFS_MSB:0];
            rd_valid <= addr_ok;
            param_read_active <= (opcode == `SFOTP_OP_READ_PARAM);
        end else if (link.sclk_fall && state == sfotp_pkg::SFOTP_ST_RD_DATA) begin
            spi_so <= next_out[7];
            spi_so_oe <= 1'b1;
            out_shift <= {next_out[6:0], 1'b1};
            out_cnt <= out_cnt + 3'h1;
            if (out_cnt == 3'h7) begin
                // Wrap to offset zero of the same area after the last low byte
                rd_offset <= (rd_offset[7:0] == `SFOTP_OFS_LAST) ? 9'h000 : rd_offset + 9'h001;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Page buffer filling during program data
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pg_valid <= 256'h0;
            pg_ptr <= 8'h00;
            pg_base <= 1'b0;
            pg_area <= 2'h1;
        end else if (eng_done || cmd_reset) begin
            pg_valid <= 256'h0;
        end else if (link.sclk_rise && state == sfotp_pkg::SFOTP_ST_ADDR
            && bit_cnt == `SFOTP_ADDR_END_BITS - 6'h01 && opcode == `SFOTP_OP_PROG_AREA && prog_ok) begin
            pg_valid <= 256'h0;
            pg_ptr <= next_addr[7:0];
            pg_base <= next_addr[`SFOTP_ADDR_OFS_MSB];
            pg_area <= next_addr[13:12];
        end else if (link.sclk_rise && state == sfotp_pkg::SFOTP_ST_PG_DATA && bit_cnt[2:0] == 3'h7) begin
            // One page of 256 bytes per program; extra bytes wrap in the page
            pg_data[pg_ptr] <= next_shift;
            pg_valid[pg_ptr] <= 1'b1;
            pg_ptr <= pg_ptr + 8'h01;
        end else if (!busy_in_progress && link.cs_rise) begin
            pg_valid <= pg_start ? pg_valid : 256'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-timed engine: program wait, commit walk, reset recovery
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            eng <= sfotp_pkg::SFOTP_ENG_IDLE;
            eng_cnt <= '0;
            commit_idx <= 8'h00;
        end else if (cmd_reset) begin
            eng <= sfotp_pkg::SFOTP_ENG_RECOVER;
            eng_cnt <= '0;
        end else begin
            unique case (eng)
                sfotp_pkg::SFOTP_ENG_IDLE: begin
                    if (pg_start) begin
                        eng <= sfotp_pkg::SFOTP_ENG_WAIT;
                        eng_cnt <= '0;
                    end
                end
                sfotp_pkg::SFOTP_ENG_WAIT: begin
                    eng_cnt <= eng_cnt + 1'b1;
                    if (eng_cnt == CNT_W'(PROG_CYCLES - 1)) begin
                        eng <= sfotp_pkg::SFOTP_ENG_COMMIT;
                        commit_idx <= 8'h00;
                    end
                end
                sfotp_pkg::SFOTP_ENG_COMMIT: begin
                    commit_idx <= commit_idx + 8'h01;
                    if (commit_idx == 8'hff) begin
                        eng <= sfotp_pkg::SFOTP_ENG_IDLE;
                    end
                end
                sfotp_pkg::SFOTP_ENG_RECOVER: begin
                    eng_cnt <= eng_cnt + 1'b1;
                    if (eng_cnt == CNT_W'(RST_CYCLES - 1)) begin
                        eng <= sfotp_pkg::SFOTP_ENG_IDLE;
                    end
                end
            endcase
        end
    end

    assign eng_done = (eng == sfotp_pkg::SFOTP_ENG_COMMIT) && (commit_idx == 8'hff);

    // Array access
    assign mem.rd_area = addr[13:12];
    assign mem.rd_offset = rd_offset;
    assign mem.wr_en = (eng == sfotp_pkg::SFOTP_ENG_COMMIT) && pg_valid[commit_idx];
    assign mem.wr_area = pg_area;
    assign mem.wr_offset = {pg_base, commit_idx};
    assign mem.wr_data = pg_data[commit_idx];

    ////////////////////////////////////////////////////////////////////////////////
    // Busy flag
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_reset || eng_done) begin
            busy_in_progress <= 1'b0;
        end else if (pg_start) begin
            busy_in_progress <= 1'b1;
        end
    end

    // Write enable latch
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_reset || eng_done || cmd_wel_clr) begin
            write_enable_latch <= 1'b0;
        end else if (cmd_wel_set) begin
            write_enable_latch <= 1'b1;
        end
    end

    // Reset arming: only an arm opcode alone keeps it, any other frame clears it unless bit_cnt ends at zero (no clock edge, or a wrap at 64 edges)
    always_ff @(posedge clk_sys) begin
        if (!rst_n || cmd_reset) begin
            reset_armed <= 1'b0;
        end else if (frame_end && bit_cnt != 6'h00) begin
            reset_armed <= short_cmd && (opcode == `SFOTP_OP_RESET_ARM);
        end
    end

    // Soft reset pulse clears pause flag, mode byte and wrap bits outside
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            soft_reset_pulse <= 1'b0;
            reset_recovery <= 1'b0;
        end else begin
            soft_reset_pulse <= cmd_reset;
            reset_recovery <= cmd_reset || ((eng == sfotp_pkg::SFOTP_ENG_RECOVER)
                && (eng_cnt != CNT_W'(RST_CYCLES - 1)));
        end
    end

endmodule

// ---- dv/sfotp_seq_sva.sv ----
// Port checker of the security-area sequencer.
// Assumes it is bound onto sfotp_seq and sees only its ports.
`timescale 1ns/1ns
module sfotp_seq_sva (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic busy_in_progress,
    input wire logic write_enable_latch,
    input wire logic soft_reset_pulse,
    input wire logic reset_recovery
);
    // One clock domain for all checks
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    oe_idle_a: assert property (spi_cs_n [*6] |-> !spi_so_oe)
        else $error("output enabled while deselected");
    pulse_once_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
        else $error("reset pulse longer than one cycle");
    pulse_recov_a: assert property (soft_reset_pulse |-> reset_recovery)
        else $error("reset without recovery");
    reset_clear_a: assert property (soft_reset_pulse |-> ##[0:1] (!busy_in_progress && !write_enable_latch))
        else $error("reset left busy or latch set");
    recov_lock_a: assert property (reset_recovery && !write_enable_latch |=> !write_enable_latch)
        else $error("latch set during recovery");
    wel_fall_a: assert property ($fell(busy_in_progress) |-> !write_enable_latch)
        else $error("latch kept after program");
    busy_wel_a: assert property ($rose(busy_in_progress) |-> write_enable_latch)
        else $error("program started without latch");
    so_edge_a: assert property (spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> !$past(spi_sclk, 2))
        else $error("output changed away from falling clock");
endmodule
bind sfotp_seq sfotp_seq_sva sfotp_seq_sva_inst (.clk_sys, .rst_n, .spi_cs_n, .spi_sclk, .spi_so, .spi_so_oe,
    .busy_in_progress, .write_enable_latch, .soft_reset_pulse, .reset_recovery);

// ---- dv/sfotp_host_model.sv ----
// Host serial controller model: mode 0, MSB first, 320 ns clock.
// Assumes clk_sys paces it; pins change at falling clk_sys.
`timescale 1ns/1ns
module sfotp_host_model (
    input wire logic clk_sys,
    input wire logic spi_so,
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_si
);
    // Idle: deselected, clock parked low
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_si = 1'b0;
    end
    // One frame of n bits; rx gathers the output line
    task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx);
        rx = 64'h0;
        @(negedge clk_sys) spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            spi_si = tx[63 - i];
            repeat (4) @(negedge clk_sys);
            spi_sclk = 1'b1;
            repeat (4) @(negedge clk_sys);
            rx = {rx[62:0], spi_so};
            spi_sclk = 1'b0;
        end
        repeat (4) @(negedge clk_sys);
        spi_cs_n = 1'b1;
        spi_si = ~spi_si;
        repeat (8) @(negedge clk_sys);
    endtask
endmodule

// ---- dv/sfotp_seq_tb.sv ----
// Testbench of the sequencer through the host model.
// Assumes short program and recovery counts.
`timescale 1ns/1ns
module sfotp_seq_tb;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] otp_area_lock_bits = 3'h0;
    logic spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe, busy_in_progress;
    logic write_enable_latch, soft_reset_pulse, reset_recovery, param_read_active;
    logic [63:0] rx;
    int n_errors = 0;
    int tests_run = 0;
    int cyc = 0;
    int pulses = 0;
    int param_seen = 0;
    int oe_seen = 0;
    always #20 clk_sys = ~clk_sys;
    sfotp_seq #(.PROG_CYCLES(20), .RST_CYCLES(200)) sfotp_seq_inst (.clk_sys, .rst_n, .spi_cs_n, .spi_sclk,
        .spi_si, .otp_area_lock_bits, .spi_so, .spi_so_oe, .busy_in_progress, .write_enable_latch,
        .soft_reset_pulse, .reset_recovery, .param_read_active);
    sfotp_host_model sfotp_host_model_inst (.clk_sys, .spi_so, .spi_cs_n, .spi_sclk, .spi_si);
    // Reset pulse count and cycle ceiling
    // Outputs are counted at the falling edge, where they are settled
    always @(negedge clk_sys) begin
        cyc++;
        if (soft_reset_pulse === 1'b1) pulses++;
        if (param_read_active === 1'b1) param_seen++;
        if (spi_so_oe === 1'b1) oe_seen++;
        if (cyc == 20000) begin
            n_errors++;
            stop_test();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            n_errors++;
        end
    endtask
    task automatic f(input logic [63:0] t, input int n);
        sfotp_host_model_inst.frame(t, n, rx);
    endtask
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        f({8'h06, 56'h0}, 8);
        chk("wel", 1, write_enable_latch);
        f({8'h42, 24'h0010fe, 16'ha53c, 16'h0}, 48);
        chk("busy", 1, busy_in_progress);
        chk("oe_seen", 0, oe_seen);
        for (int k = 0; k < 600 && busy_in_progress !== 1'b0; k++) @(negedge clk_sys);
        chk("wel", 0, write_enable_latch);
        f({8'h48, 24'h0010fe, 32'h0}, 64);
        chk("read", 32'ha53cff, {8'h00, rx[23:0]});
        chk("oe_seen", 1, oe_seen != 0);
        f({8'h42, 24'h002000, 32'h0}, 40);
        chk("busy", 0, busy_in_progress);
        // Locked area with latch set
        otp_area_lock_bits = 3'h4;
        f({8'h06, 56'h0}, 8);
        f({8'h42, 24'h003000, 32'h0}, 40);
        chk("busy", 0, busy_in_progress);
        chk("wel", 1, write_enable_latch);
        f({8'h42, 24'h0010fe, 8'h0f, 24'h0}, 40);
        for (int k = 0; k < 600 && busy_in_progress !== 1'b0; k++) @(negedge clk_sys);
        f({8'h48, 24'h0010fe, 32'h0}, 48);
        chk("and", 32'h05, {24'h0, rx[7:0]});
        f({8'h48, 24'h003000, 32'h0}, 48);
        chk("area3", 32'hff, {24'h0, rx[7:0]});
        chk("param_seen", 0, param_seen);
        f({8'h5a, 56'h0}, 48);
        chk("param", 32'hff, {24'h0, rx[7:0]});
        chk("param_seen", 1, param_seen != 0);
        // Arm, other command, reset: no reset
        f({8'h66, 56'h0}, 8);
        f({8'h06, 56'h0}, 8);
        f({8'h99, 56'h0}, 8);
        chk("pulses", 0, pulses);
        chk("busy", 0, busy_in_progress);
        f({8'h66, 56'h0}, 8);
        f({8'h99, 56'h0}, 8);
        chk("pulses", 1, pulses);
        chk("wel", 0, write_enable_latch);
        chk("recovery", 1, reset_recovery);
        f({8'h06, 56'h0}, 8);
        chk("wel", 0, write_enable_latch);
        for (int k = 0; k < 400 && reset_recovery !== 1'b0; k++) @(negedge clk_sys);
        f({8'h06, 56'h0}, 8);
        chk("wel", 1, write_enable_latch);
        // Write disable drops the latch again
        f({8'h04, 56'h0}, 8);
        chk("wel", 0, write_enable_latch);
        stop_test();
    end
endmodule
